// ===== pmrb_bank.sv
// Purpose: management register bank, offsets 5h to Ah, Dh to Fh and 11h to 13h
// Assumes: one access per request pulse, inputs synchronous to clock
// Notes:   read data answers one cycle after the read pulse
// How it works
// - partner pause field shown in two bits
// - parallel detection fault latches until read
// - page received latches until read
// - next page transmit fields with toggle readback
// - partner next page shown read only
// - three-bit test mode field selects test
// - manual enable picks master or slave value
// - port type preference only without manual
// - 1000 duplex adverts, half from strap
// - configuration fault latches, clears on read
// - resolved master or slave role reported
// - local and remote receiver status mirrored
// - partner 1000 full/half ability reported
// - idle error counter, clears on read
// - indirect control holds device and mode
// - indirect data is address or data, incrementing
// - extended status fixed ability bits
// - remote loopback bit drives loopback enable
// - cable test bit runs and self clears
// - pair select, result and fault distance
// - separate 1000 and 100 link ok bits
`timescale 1ns/10ps
module pmrb_bank
    import pmrb_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // management access
    input  wire pmrb_req_s   req,
    output logic [15:0]      rdData,
    output logic             rdValid,
    // strap sampled at reset release
    input  wire logic        strapHalfDup,
    // link status
    input  wire pmrb_stat_s  stat,
    // indirect register port
    output pmrb_mmd_s        mmd,
    input  wire logic [15:0] mmdRdata,
    // cable diagnostic engine
    output logic             cableStart,
    output logic [1:0]       cablePair,
    input  wire pmrb_cable_s cable,
    // control outputs
    output logic [2:0]       testMode,
    output logic             manualMsEn,
    output logic             manualMaster,
    output logic             portMulti,
    output logic             adv1000Fd,
    output logic             adv1000Hd,
    output logic             npNextPage,
    output logic             npMsgPage,
    output logic             npAck2,
    output logic [10:0]      npMessage,
    output logic             remoteLoop
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction : hit

    wire logic rdEv    = req.rd;
    wire logic wrEv    = req.wr;
    wire logic rdExp   = rdEv && hit(req.addr, OFF_AN_EXPANSION);
    wire logic rdGst   = rdEv && hit(req.addr, OFF_GIG_STATUS);
    wire logic wrNp    = wrEv && hit(req.addr, OFF_NP_TRANSMIT);
    wire logic wrGc    = wrEv && hit(req.addr, OFF_GIG_CONTROL);
    wire logic wrIc    = wrEv && hit(req.addr, OFF_IND_CONTROL);
    wire logic rdId    = rdEv && hit(req.addr, OFF_IND_DATA);
    wire logic wrId    = wrEv && hit(req.addr, OFF_IND_DATA);
    wire logic wrLoop  = wrEv && hit(req.addr, OFF_REMOTE_LOOP);
    wire logic wrCable = wrEv && hit(req.addr, OFF_CABLE_TEST);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic        strapDone_reg;
    logic        parFault_reg;
    logic        pageRcvd_reg;
    logic        msFault_reg;
    logic [7:0]  idleErr_reg;
    logic [1:0]  indMode_reg;
    logic [8:0]  indRsvd_reg;
    logic [4:0]  indDev_reg;
    logic [15:0] indAddr_reg;
    logic [6:0]  loopHigh_reg;
    logic [6:0]  loopLow_reg;
    logic        cableRsvd14_reg;
    logic [1:0]  cableRsvd_reg;
    logic [1:0]  cableStatus_reg;
    logic [7:0]  cableDist_reg;
    pmrb_cable_e cableState_reg;

    // ----------------------------------------
    // latch-high flags: a set in the read cycle wins
    // ----------------------------------------
    wire logic parFault_next = stat.parDetFault | (parFault_reg & ~rdExp);
    wire logic pageRcvd_next = stat.pageRcvd | (pageRcvd_reg & ~rdExp);
    wire logic msFault_next  = stat.msFault | (msFault_reg & ~rdGst);

    // counter saturates so a long error burst cannot wrap to a small count
    wire logic       idleInc      = stat.idleRxError && (idleErr_reg != IDLE_ERR_MAX);
    wire logic [7:0] idleBase     = rdGst ? 8'h00 : idleErr_reg;
    wire logic [7:0] idleErr_next = stat.idleRxError ? (rdGst ? 8'h01 :
                                    (idleInc ? idleErr_reg + 8'h01 : idleErr_reg))
                                    : idleBase;

    // ----------------------------------------
    // indirect access portal
    // ----------------------------------------
    wire logic isData  = (indMode_reg != IND_MODE_ADDR);
    wire logic incRead = (indMode_reg == IND_MODE_INC_RW);
    wire logic incWrite = (indMode_reg == IND_MODE_INC_RW) || (indMode_reg == IND_MODE_INC_WR);
    wire logic dataRd  = rdId && isData;
    wire logic dataWr  = wrId && isData;
    wire logic [15:0] indAddr_next = (wrId && !isData) ? req.wdata :
                                     ((dataRd && incRead) || (dataWr && incWrite)) ?
                                     indAddr_reg + 16'h0001 : indAddr_reg;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire logic [15:0] wExp = {11'h000, parFault_reg, stat.partnerNpAble, 1'b1,
                              pageRcvd_reg, stat.partnerAnAble};
    wire logic [15:0] wNp  = {npNextPage, 1'b0, npMsgPage, npAck2, stat.npToggle,
                              npMessage};
    wire logic [15:0] wPnp = stat.partnerNp;
    wire logic [15:0] wGc  = {testMode, manualMsEn, manualMaster, portMulti,
                              adv1000Fd, adv1000Hd, 8'h00};
    wire logic [15:0] wGst = {msFault_reg, stat.msIsMaster, stat.locRcvrOk,
                              stat.remRcvrOk, stat.partner1000Fd,
                              stat.partner1000Hd, 2'b00, idleErr_reg};
    wire logic [15:0] wIc  = {indMode_reg, indRsvd_reg, indDev_reg};
    wire logic [15:0] wId  = isData ? mmdRdata : indAddr_reg;
    wire logic [15:0] wLp  = {loopHigh_reg, remoteLoop, loopLow_reg, 1'b0};
    wire logic [15:0] wCt  = {(cableState_reg == CT_RUN), cableRsvd14_reg, cablePair,
                              cableRsvd_reg, cableStatus_reg, cableDist_reg};
    wire logic [15:0] wPma = {13'h0000, stat.link1000Ok, stat.link100Ok, 1'b0};
    // pause bits ride in the partner base word at 11:10
    wire logic [15:0] wPb  = stat.partnerBase;

    logic [15:0] rdMux;
    always_comb begin
        case (req.addr)
            OFF_PARTNER_BASE: rdMux = wPb;
            OFF_AN_EXPANSION: rdMux = wExp;
            OFF_NP_TRANSMIT:  rdMux = wNp;
            OFF_PARTNER_NP:   rdMux = wPnp;
            OFF_GIG_CONTROL:  rdMux = wGc;
            OFF_GIG_STATUS:   rdMux = wGst;
            OFF_IND_CONTROL:  rdMux = wIc;
            OFF_IND_DATA:     rdMux = wId;
            OFF_EXT_STATUS:   rdMux = EXT_STATUS_VALUE;
            OFF_REMOTE_LOOP:  rdMux = wLp;
            OFF_CABLE_TEST:   rdMux = wCt;
            OFF_PMA_LINK:     rdMux = wPma;
            default:          rdMux = WORD_ZERO;
        endcase
    end

    // ----------------------------------------
    // read answer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rdData  <= WORD_ZERO;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEv;
            if (rdEv) begin
                rdData <= rdMux;
            end
        end
    end

    // ----------------------------------------
    // indirect port
    // ----------------------------------------
    // the port address follows the pointer so back-to-back incrementing reads
    // see the next word; only a write strobe pins it to the pre-increment word.
    // limitation: a data read in the cycle right after an incrementing write
    // still sees the address just written
    wire logic [15:0] mmdAddr_next = dataWr ? indAddr_reg : indAddr_next;

    always_ff @(posedge clock) begin
        if (rst) begin
            mmd <= '0;
        end else begin
            mmd.rd    <= dataRd;
            mmd.wr    <= dataWr;
            mmd.dev   <= indDev_reg;
            mmd.addr  <= mmdAddr_next;
            mmd.wdata <= req.wdata;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            parFault_reg <= 1'b0;
            pageRcvd_reg <= 1'b0;
            msFault_reg  <= 1'b0;
        end else begin
            parFault_reg <= parFault_next;
            pageRcvd_reg <= pageRcvd_next;
            msFault_reg  <= msFault_next;
        end
    end

    // ----------------------------------------
    // idle error counter
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            idleErr_reg <= 8'h00;
        end else begin
            idleErr_reg <= idleErr_next;
        end
    end

    // ----------------------------------------
    // next page transmit
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            npNextPage <= 1'b0;
            npMsgPage  <= NP_MSGPAGE_RESET;
            npAck2     <= 1'b0;
            npMessage  <= NP_MSG_RESET;
        end else if (wrNp) begin
            npNextPage <= req.wdata[15];
            npMsgPage  <= req.wdata[13];
            npAck2     <= req.wdata[12];
            npMessage  <= req.wdata[10:0];
        end
    end

    // ----------------------------------------
    // gigabit control
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            testMode      <= TEST_NORMAL;
            manualMsEn    <= 1'b0;
            manualMaster  <= 1'b0;
            portMulti     <= 1'b0;
            adv1000Fd     <= GIG_FD_ADV_RESET;
            adv1000Hd     <= 1'b0;
            strapDone_reg <= 1'b0;
        end else begin
            // strap is caught on the first clock after reset release
            strapDone_reg <= 1'b1;
            if (!strapDone_reg) begin
                adv1000Hd <= strapHalfDup;
            end else if (wrGc) begin
                adv1000Hd <= req.wdata[8];
            end
            if (wrGc) begin
                // reserved test codes fall back to normal operation
                testMode     <= (req.wdata[15:13] > TEST_LAST_VALID) ?
                                TEST_NORMAL : req.wdata[15:13];
                manualMsEn   <= req.wdata[12];
                manualMaster <= req.wdata[11];
                portMulti    <= req.wdata[10];
                adv1000Fd    <= req.wdata[9];
            end
        end
    end

    // ----------------------------------------
    // indirect control, loopback
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            indMode_reg  <= IND_MODE_ADDR;
            indRsvd_reg  <= 9'h000;
            indDev_reg   <= 5'h00;
            indAddr_reg  <= IND_DATA_RESET;
            loopHigh_reg <= LOOP_HIGH_RESET;
            loopLow_reg  <= LOOP_LOW_RESET;
            remoteLoop   <= 1'b0;
        end else begin
            if (wrIc) begin
                indMode_reg <= req.wdata[15:14];
                indRsvd_reg <= req.wdata[13:5];
                indDev_reg  <= req.wdata[4:0];
            end
            indAddr_reg <= indAddr_next;
            if (wrLoop) begin
                loopHigh_reg <= req.wdata[15:9];
                remoteLoop   <= req.wdata[8];
                loopLow_reg  <= req.wdata[7:1];
            end
        end
    end

    // ----------------------------------------
    // cable diagnostic
    // ----------------------------------------
    wire logic cableGo = wrCable && req.wdata[15] && (cableState_reg == CT_IDLE);

    always_ff @(posedge clock) begin
        if (rst) begin
            cableState_reg  <= CT_IDLE;
            cableStart      <= 1'b0;
            cablePair       <= 2'b00;
            cableRsvd14_reg <= 1'b0;
            cableRsvd_reg   <= 2'b00;
            cableStatus_reg <= 2'b00;
            cableDist_reg   <= 8'h00;
        end else begin
            cableStart <= cableGo;
            if (wrCable && cableState_reg == CT_IDLE) begin
                cablePair       <= req.wdata[13:12];
                cableRsvd14_reg <= req.wdata[14];
                cableRsvd_reg   <= req.wdata[11:10];
            end
            case (cableState_reg)
                CT_IDLE: begin
                    if (cableGo) begin
                        cableState_reg <= CT_RUN;
                    end
                end
                CT_RUN: begin
                    // writing 0 aborts; results stay from the last finished test
                    if (wrCable && !req.wdata[15]) begin
                        cableState_reg <= CT_IDLE;
                    end else if (cable.done) begin
                        cableState_reg  <= CT_IDLE;
                        cableStatus_reg <= cable.status;
                        cableDist_reg   <= cable.distance;
                    end
                end
                default: cableState_reg <= CT_IDLE;
            endcase
        end
    end
endmodule : pmrb_bank

// ===== pmrb_pkg.sv
// Purpose: constants and carriers for the management register bank
// Assumes: 16-bit Clause 22 register words, 5-bit register offsets
// Notes:   offsets are the printed register numbers
package pmrb_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [4:0] OFF_PARTNER_BASE  = 5'h05;
    localparam logic [4:0] OFF_AN_EXPANSION  = 5'h06;
    localparam logic [4:0] OFF_NP_TRANSMIT   = 5'h07;
    localparam logic [4:0] OFF_PARTNER_NP    = 5'h08;
    localparam logic [4:0] OFF_GIG_CONTROL   = 5'h09;
    localparam logic [4:0] OFF_GIG_STATUS    = 5'h0a;
    localparam logic [4:0] OFF_IND_CONTROL   = 5'h0d;
    localparam logic [4:0] OFF_IND_DATA      = 5'h0e;
    localparam logic [4:0] OFF_EXT_STATUS    = 5'h0f;
    localparam logic [4:0] OFF_REMOTE_LOOP   = 5'h11;
    localparam logic [4:0] OFF_CABLE_TEST    = 5'h12;
    localparam logic [4:0] OFF_PMA_LINK      = 5'h13;

    // ----------------------------------------
    // reset values and fixed fields
    // ----------------------------------------
    localparam logic [10:0] NP_MSG_RESET      = 11'h001;
    localparam logic        NP_MSGPAGE_RESET  = 1'b1;
    localparam logic        GIG_FD_ADV_RESET  = 1'b1;
    localparam logic [6:0]  LOOP_HIGH_RESET   = 7'h00;
    localparam logic [6:0]  LOOP_LOW_RESET    = 7'h7a;
    localparam logic [15:0] EXT_STATUS_VALUE  = 16'h3000;
    localparam logic [15:0] IND_DATA_RESET    = 16'h0000;
    localparam logic [15:0] WORD_ZERO         = 16'h0000;
    localparam logic [7:0]  IDLE_ERR_MAX      = 8'hff;

    // ----------------------------------------
    // field encodings
    // ----------------------------------------
    localparam logic [1:0] IND_MODE_ADDR     = 2'b00;
    localparam logic [1:0] IND_MODE_DATA     = 2'b01;
    localparam logic [1:0] IND_MODE_INC_RW   = 2'b10;
    localparam logic [1:0] IND_MODE_INC_WR   = 2'b11;
    localparam logic [2:0] TEST_NORMAL       = 3'b000;
    localparam logic [2:0] TEST_LAST_VALID   = 3'b100;

    typedef enum {CT_IDLE, CT_RUN} pmrb_cable_e;

    // management access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pmrb_req_s;

    // status from the auto-negotiation and PMA logic
    typedef struct packed {
        logic        parDetFault;
        logic        pageRcvd;
        logic [15:0] partnerBase;
        logic        partnerNpAble;
        logic        partnerAnAble;
        logic [15:0] partnerNp;
        logic        npToggle;
        logic        msFault;
        logic        msIsMaster;
        logic        locRcvrOk;
        logic        remRcvrOk;
        logic        partner1000Fd;
        logic        partner1000Hd;
        logic        idleRxError;
        logic        link1000Ok;
        logic        link100Ok;
    } pmrb_stat_s;

    // cable diagnostic engine result
    typedef struct packed {
        logic       done;
        logic [1:0] status;
        logic [7:0] distance;
    } pmrb_cable_s;

    // indirect register port
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pmrb_mmd_s;
endpackage : pmrb_pkg

// ===== pmrb_bank_sva.sv
// Purpose: port-level checks of the register bank
// Assumes: sees only the bank's ports
// Notes:   attached to every bank instance by bind
`timescale 1ns/10ps
module pmrb_bank_sva
    import pmrb_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // management access
    input wire pmrb_req_s   req,
    input wire logic [15:0] rdData,
    input wire logic        rdValid,
    // indirect and cable
    input wire pmrb_mmd_s   mmd,
    input wire logic        cableStart,
    // controls
    input wire logic [2:0]  testMode,
    input wire logic        manualMsEn,
    input wire logic        manualMaster,
    input wire logic [10:0] npMessage,
    input wire logic        remoteLoop
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence wrAt(logic [4:0] a);
        req.wr && req.addr == a;
    endsequence
    read_answer_a: assert property (req.rd |=> rdValid)
        else $error("read not answered");
    no_stray_valid_a: assert property (!req.rd |=> !rdValid)
        else $error("valid without read");
    // reserved codes fall back to normal operation
    test_code_a: assert property (wrAt(OFF_GIG_CONTROL) |=> testMode ==
        (($past(req.wdata[15:13]) > TEST_LAST_VALID) ? TEST_NORMAL : $past(req.wdata[15:13])))
        else $error("test mode wrong");
    manual_role_a: assert property (wrAt(OFF_GIG_CONTROL) |=>
        {manualMsEn, manualMaster} == $past(req.wdata[12:11])) else $error("manual role wrong");
    np_message_a: assert property (wrAt(OFF_NP_TRANSMIT) |=>
        npMessage == $past(req.wdata[10:0])) else $error("message field wrong");
    loop_enable_a: assert property (wrAt(OFF_REMOTE_LOOP) |=>
        remoteLoop == $past(req.wdata[8])) else $error("loopback wrong");
    cable_start_a: assert property (cableStart |->
        $past(req.wr && req.addr == OFF_CABLE_TEST && req.wdata[15])) else $error("stray start");
    mmd_write_a: assert property (mmd.wr |->
        $past(req.wr && req.addr == OFF_IND_DATA)) else $error("stray indirect write");
    ext_status_a: assert property (req.rd && req.addr == OFF_EXT_STATUS |=>
        rdData == EXT_STATUS_VALUE) else $error("extended status wrong");
endmodule : pmrb_bank_sva
bind pmrb_bank pmrb_bank_sva pmrb_bank_sva_i (.clock(clock), .rst(rst), .req(req),
    .rdData(rdData), .rdValid(rdValid), .mmd(mmd), .cableStart(cableStart),
    .testMode(testMode), .manualMsEn(manualMsEn), .manualMaster(manualMaster),
    .npMessage(npMessage), .remoteLoop(remoteLoop));

// ===== pmrb_far_model.sv
// Purpose: indirect register file and cable engine beside the bank
// Assumes: storage wraps at 16 words
// Notes:   results are junk outside the done pulse
`timescale 1ns/10ps
module pmrb_far_model
    import pmrb_pkg::*;
#(
    parameter int TEST_CYCLES = 12
)
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // indirect register side
    input wire pmrb_mmd_s   mmd,
    output logic [15:0]     mmdRdata,
    // cable engine side
    input wire logic        cableStart,
    input wire logic [1:0]  cablePair,
    output pmrb_cable_s     cable
);
    logic [15:0] mem [16];
    int          left;
    assign mmdRdata = mem[mmd.addr[3:0]];
    initial begin
        cable = '0;
        left = 0;
        for (int i = 0; i < 16; i++) mem[i] = 16'h0f00 + 16'(i);
    end
    always @(posedge clock) begin
        // status lines wander so a stale sample cannot pass
        cable <= {1'b0, ~cable.status, cable.distance + 8'h35};
        if (mmd.wr) mem[mmd.addr[3:0]] <= mmd.wdata;
        if (rst) left <= 0;
        else if (cableStart) left <= TEST_CYCLES;
        else if (left == 1) begin
            left <= 0;
            cable <= {1'b1, (cablePair == 2'b11) ? 2'b00 : cablePair, 8'h20 + 8'(cablePair)};
        end
        else if (left > 0) left <= left - 1;
    end
endmodule : pmrb_far_model

// ===== pmrb_bank_tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: far model answers indirect and cable traffic
// Notes:   read results are queued and compared by a monitor
`timescale 1ns/10ps
module pmrb_bank_tb_top
    import pmrb_pkg::*;
;
    logic        clock = 0;
    logic        rst = 1;
    pmrb_req_s   req = '0;
    pmrb_stat_s  stat = '0;
    logic        strapHalfDup = 1;
    logic [15:0] rdData, mmdRdata, ex6, gs, prev;
    logic        rdValid, cableStart;
    logic [1:0]  cablePair;
    pmrb_mmd_s   mmd;
    pmrb_cable_s cable;
    logic [31:0] seed = 32'h746e_f7eb;
    logic [15:0] expq [$];
    int          mismatches = 0;
    int          num_checks = 0;
    always #5 clock = ~clock;
    pmrb_bank pmrb_bank_i (.clock(clock), .rst(rst), .req(req), .rdData(rdData),
        .rdValid(rdValid), .strapHalfDup(strapHalfDup), .stat(stat), .mmd(mmd),
        .mmdRdata(mmdRdata), .cableStart(cableStart), .cablePair(cablePair), .cable(cable),
        .testMode(), .manualMsEn(), .manualMaster(), .portMulti(), .adv1000Fd(),
        .adv1000Hd(), .npNextPage(), .npMsgPage(), .npAck2(), .npMessage(), .remoteLoop());
    pmrb_far_model pmrb_far_model_i (.clock(clock), .rst(rst), .mmd(mmd),
        .mmdRdata(mmdRdata), .cableStart(cableStart), .cablePair(cablePair), .cable(cable));
    // ----------------------------------------
    // drivers and compare
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic conclude;
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request stays up across back-to-back calls; idle drops it
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expq.push_back(e);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clock);
    endtask : rd
    task automatic idle;
        req = '0;
        @(negedge clock);
    endtask : idle
    always @(negedge clock) begin
        if (rdValid === 1'b1) begin
            if (expq.size() == 0) chk(rdData, 16'hxxxx);
            else chk(rdData, expq.pop_front());
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clock);
        rst = 0;
        repeat (3) @(negedge clock);
        rd(OFF_NP_TRANSMIT, 16'h2001);
        rd(OFF_GIG_CONTROL, 16'h0300);
        rd(OFF_REMOTE_LOOP, 16'h00f4);
        rd(OFF_IND_DATA, IND_DATA_RESET);
        rd(OFF_EXT_STATUS, EXT_STATUS_VALUE);
        rd(5'h0b, WORD_ZERO);
        wr(5'h10, 16'hffff);
        rd(5'h10, WORD_ZERO);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(lfsr(seed));
            stat.partnerBase = seed[15:0];
            stat.partnerNp = seed[31:16];
            {stat.msIsMaster, stat.locRcvrOk, stat.remRcvrOk, stat.partner1000Fd,
                stat.partner1000Hd, stat.link1000Ok, stat.link100Ok, stat.partnerNpAble,
                stat.partnerAnAble} = seed[8:0] ^ seed[24:16];
            gs = {1'b0, stat.msIsMaster, stat.locRcvrOk, stat.remRcvrOk,
                stat.partner1000Fd, stat.partner1000Hd, 10'h000};
            ex6 = {11'h000, 1'b0, stat.partnerNpAble, 1'b1, 1'b0, stat.partnerAnAble};
            idle();
            rd(OFF_PARTNER_BASE, stat.partnerBase);
            rd(OFF_PARTNER_NP, stat.partnerNp);
            rd(OFF_GIG_STATUS, gs);
            rd(OFF_AN_EXPANSION, ex6);
            rd(OFF_PMA_LINK, {13'h0000, stat.link1000Ok, stat.link100Ok, 1'b0});
        end
        idle();
        {stat.parDetFault, stat.pageRcvd, stat.msFault, stat.idleRxError} = 4'hf;
        @(negedge clock);
        {stat.parDetFault, stat.pageRcvd, stat.msFault} = 3'h0;
        repeat (2) @(negedge clock);
        stat.idleRxError = 1'b0;
        rd(OFF_AN_EXPANSION, ex6 | 16'h0012);
        rd(OFF_GIG_STATUS, gs | 16'h8003);
        rd(OFF_AN_EXPANSION, ex6);
        rd(OFF_GIG_STATUS, gs);
        wr(5'h00, 16'h0140);
        for (int c = 0; c < 8; c++) begin
            wr(OFF_GIG_CONTROL, {3'(c), 5'b10110, 8'hff});
            rd(OFF_GIG_CONTROL, {(c > 4) ? 3'b000 : 3'(c), 5'b10110, 8'h00});
        end
        wr(OFF_NP_TRANSMIT, 16'hf7ff);
        rd(OFF_NP_TRANSMIT, {4'b1011, stat.npToggle, 11'h7ff});
        wr(OFF_REMOTE_LOOP, 16'h01f5);
        rd(OFF_REMOTE_LOOP, 16'h01f4);
        wr(OFF_IND_CONTROL, 16'h0002);
        wr(OFF_IND_DATA, 16'h0003);
        wr(OFF_IND_CONTROL, 16'h4002);
        wr(OFF_IND_DATA, 16'ha5a5);
        idle();
        rd(OFF_IND_DATA, 16'ha5a5);
        rd(OFF_IND_DATA, 16'ha5a5);
        wr(OFF_IND_CONTROL, 16'h8002);
        rd(OFF_IND_DATA, 16'ha5a5);
        rd(OFF_IND_DATA, 16'h0f04);
        wr(OFF_IND_CONTROL, 16'hc002);
        rd(OFF_IND_CONTROL, 16'hc002);
        rd(OFF_IND_DATA, 16'h0f05);
        wr(OFF_IND_DATA, 16'h1234);
        wr(OFF_IND_CONTROL, 16'h0002);
        rd(OFF_IND_DATA, 16'h0006);
        prev = 16'h0000;
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CABLE_TEST, {2'b10, 2'(p), 12'h000});
            rd(OFF_CABLE_TEST, {2'b10, 2'(p), prev[11:0]});
            idle();
            for (int w = 0; w < 100 && cable.done !== 1'b1; w++) @(negedge clock);
            // a hung engine falls through to the verdict
            if (cable.done !== 1'b1) begin
                mismatches++;
                break;
            end
            idle();
            prev = {4'h0, 2'b00, (p == 3) ? 2'b00 : 2'(p), 8'h20 + 8'(p)};
            rd(OFF_CABLE_TEST, {2'b00, 2'(p), prev[11:0]});
        end
        // abort: results of the last finished test must survive
        wr(OFF_CABLE_TEST, 16'h9000);
        wr(OFF_CABLE_TEST, 16'h0000);
        repeat (16) idle();
        rd(OFF_CABLE_TEST, {4'h1, prev[11:0]});
        idle();
        idle();
        if (expq.size() != 0) mismatches++;
        conclude();
    end
endmodule : pmrb_bank_tb_top
